//--- rtl/auto_mute_emergency_ramp.v
// silence auto mute, emergency volume ramp and loop bandwidth setting
//
// How it works
// R1 - clock error or power loss ramps volume with the emergency settings only
// R2 - emergency rate: update every 1, 2, 4 samples; code 11 mutes at once
// R3 - emergency step per update: 4, 2, 1 or 0.5 db
// R4 - emergency ramp register resets to 0x30
// R5 - joint bit 2: mute both only when both qualify, else independent
// R6 - bit 1 enables right channel auto mute
// R7 - bit 0 enables left channel auto mute
// R8 - mute setup register resets to 0x07
// R9 - left zero run must reach threshold of bits 6 to 4
// R10 - threshold codes give 11.5 ms up to 5.33 s at 96 khz
// R11 - right zero run counted apart, threshold from bits 2 to 0
// R12 - thresholds are fixed sample counts, delay scales with rate
// R13 - bits 6 to 5 pick loop bandwidth 80, 100, 120 or 175 khz
// R14 - a non-zero sample unmutes the channel and restarts its count
// R15 - reserved bits store and read back, with no effect
`timescale 1ns/1ps
module auto_mute_emergency_ramp #(
   parameter SAMPLE_W = 24,
   parameter CNT_W = 20
)(
   input wire clk_sys_i,
   input wire rst_n_i,
   input wire [7:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [7:0] rdata_o,
   input wire sample_valid_i,
   input wire [SAMPLE_W-1:0] left_sample_i,
   input wire [SAMPLE_W-1:0] right_sample_i,
   input wire [7:0] volume_i,
   input wire soft_mute_i,
   input wire [1:0] normal_speed_i,
   input wire [1:0] normal_step_i,
   input wire clock_error_i,
   input wire power_loss_i,
   output reg [7:0] volume_o,
   output reg left_mute_o,
   output reg right_mute_o,
   output reg both_muted_o,
   output reg emergency_o,
   output reg [1:0] loop_bandwidth_select_o
);
`include "auto_mute_consts.vh"

   // ***************************************************
   // registers
   // ***************************************************
   reg [7:0] emergency_ramp_setup_r;
   reg [7:0] silence_mute_setup_r;
   reg [7:0] silence_hold_times_r;
   reg [7:0] loop_bandwidth_setup_r;
   reg [7:0] rdata_nxt;
   wire wr_emergency;
   wire wr_mute_setup;
   wire wr_hold_times;
   wire wr_bandwidth;

   assign wr_emergency = wr_i & (addr_i == `ADDR_EMERGENCY_RAMP_SETUP);
   assign wr_mute_setup = wr_i & (addr_i == `ADDR_SILENCE_MUTE_SETUP);
   assign wr_hold_times = wr_i & (addr_i == `ADDR_SILENCE_HOLD_TIMES);
   assign wr_bandwidth = wr_i & (addr_i == `ADDR_LOOP_BANDWIDTH_SETUP);

   // whole bytes stored, reserved bits included [R15]
   always @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
         emergency_ramp_setup_r <= `RST_EMERGENCY_RAMP_SETUP; // [R4]
      else if (wr_emergency)
         emergency_ramp_setup_r <= wdata_i;
   end

   always @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
         silence_mute_setup_r <= `RST_SILENCE_MUTE_SETUP; // [R8]
      else if (wr_mute_setup)
         silence_mute_setup_r <= wdata_i;
   end

   always @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
         silence_hold_times_r <= `RST_SILENCE_HOLD_TIMES;
      else if (wr_hold_times)
         silence_hold_times_r <= wdata_i;
   end

   always @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
         loop_bandwidth_setup_r <= `RST_LOOP_BANDWIDTH_SETUP;
      else if (wr_bandwidth)
         loop_bandwidth_setup_r <= wdata_i;
   end

   // ***************************************************
   // read port, data valid only in the cycle after rd_i
   // ***************************************************
   always @*
   begin
      rdata_nxt = 8'h00;
      if (rd_i)
      begin
         case (addr_i)
            `ADDR_EMERGENCY_RAMP_SETUP:
               rdata_nxt = emergency_ramp_setup_r; // [R15]
            `ADDR_SILENCE_MUTE_SETUP:
               rdata_nxt = silence_mute_setup_r;
            `ADDR_SILENCE_HOLD_TIMES:
               rdata_nxt = silence_hold_times_r;
            `ADDR_LOOP_BANDWIDTH_SETUP:
               rdata_nxt = loop_bandwidth_setup_r;
            `ADDR_MUTE_STATUS:
               rdata_nxt = {4'h0, emergency_o, both_muted_o,
                  right_mute_o, left_mute_o};
            `ADDR_VOLUME_STATUS:
               rdata_nxt = volume_o;
            default:
               rdata_nxt = 8'h00;
         endcase
      end
   end

   always @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
         rdata_o <= 8'h00;
      else
         rdata_o <= rdata_nxt;
   end

   // ***************************************************
   // loop bandwidth select
   // ***************************************************
   always @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
         loop_bandwidth_select_o <= 2'b00;
      else
         loop_bandwidth_select_o <=
            loop_bandwidth_setup_r[`LOOP_BW_HI:`LOOP_BW_LO]; // [R13]
   end

   // ***************************************************
   // zero run counters, one per channel
   // ***************************************************
   wire [1:0] zero_in;
   wire [1:0] silent;
   wire [5:0] thr_sel;

   assign zero_in[0] = (left_sample_i == {SAMPLE_W{1'b0}});
   assign zero_in[1] = (right_sample_i == {SAMPLE_W{1'b0}});
   assign thr_sel[2:0] =
      silence_hold_times_r[`THR_LEFT_HI:`THR_LEFT_LO]; // [R9] [R10]
   assign thr_sel[5:3] =
      silence_hold_times_r[`THR_RIGHT_HI:`THR_RIGHT_LO]; // [R11] [R10]

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch = ch + 1)
      begin : g_chan
         silence_counter #(
            .CNT_W(CNT_W)
         ) u_count (
            .clk_sys_i(clk_sys_i),
            .rst_n_i(rst_n_i),
            .sample_valid_i(sample_valid_i),
            .sample_zero_i(zero_in[ch]),
            .thr_sel_i(thr_sel[ch*3+2:ch*3]),
            .silent_o(silent[ch])
         );
      end
   endgenerate

   // ***************************************************
   // mute decision
   // ***************************************************
   wire left_q;
   wire right_q;
   wire joint;
   reg left_mute_nxt;
   reg right_mute_nxt;

   assign left_q = silent[0] &
      silence_mute_setup_r[`MUTE_EN_LEFT_BIT]; // [R7]
   assign right_q = silent[1] &
      silence_mute_setup_r[`MUTE_EN_RIGHT_BIT]; // [R6]
   assign joint = silence_mute_setup_r[`MUTE_JOINT_BIT];

   always @*
   begin
      if (joint)
      begin
         left_mute_nxt = left_q & right_q; // [R5]
         right_mute_nxt = left_q & right_q; // [R5]
      end
      else
      begin
         left_mute_nxt = left_q; // [R5]
         right_mute_nxt = right_q; // [R5]
      end
   end

   always @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         left_mute_o <= 1'b0;
         right_mute_o <= 1'b0;
         both_muted_o <= 1'b0;
      end
      else
      begin
         left_mute_o <= left_mute_nxt; // [R14]
         right_mute_o <= right_mute_nxt; // [R14]
         both_muted_o <= left_mute_nxt & right_mute_nxt;
      end
   end

   // ***************************************************
   // ramp source, emergency settings win over soft mute
   // ***************************************************
   localparam [1:0] MODE_FOLLOW = 2'b00;
   localparam [1:0] MODE_SOFT = 2'b01;
   localparam [1:0] MODE_EMERGENCY = 2'b10;

   wire emg;
   reg [1:0] mode;
   reg [1:0] speed;
   reg [1:0] step_code;
   reg ramping;
   reg [7:0] step;
   reg [1:0] div_lim;

   assign emg = clock_error_i | power_loss_i;

   always @*
   begin
      if (emg)
         mode = MODE_EMERGENCY; // [R1]
      else if (soft_mute_i)
         mode = MODE_SOFT;
      else
         mode = MODE_FOLLOW;
   end

   always @*
   begin
      case (mode)
         MODE_EMERGENCY:
         begin
            speed = emergency_ramp_setup_r[`EMG_SPEED_HI:`EMG_SPEED_LO]; // [R1]
            step_code = emergency_ramp_setup_r[`EMG_STEP_HI:`EMG_STEP_LO]; // [R1]
            ramping = 1'b1;
         end
         MODE_SOFT:
         begin
            speed = normal_speed_i;
            step_code = normal_step_i;
            ramping = 1'b1;
         end
         default:
         begin
            speed = normal_speed_i;
            step_code = normal_step_i;
            ramping = 1'b0;
         end
      endcase
   end

   // ***************************************************
   // step size and update rate decode
   // ***************************************************
   always @*
   begin
      case (step_code)
         2'b00: step = `VOL_STEP_4DB; // [R3]
         2'b01: step = `VOL_STEP_2DB; // [R3]
         2'b10: step = `VOL_STEP_1DB; // [R3]
         default: step = `VOL_STEP_HALF_DB; // [R3]
      endcase
      case (speed)
         `SPEED_EVERY_1: div_lim = 2'd0; // [R2]
         `SPEED_EVERY_2: div_lim = 2'd1; // [R2]
         `SPEED_EVERY_4: div_lim = 2'd3; // [R2]
         default: div_lim = 2'd0; // instant mute bypasses the divider
      endcase
   end

   // ***************************************************
   // volume ramp, saturating at mute
   // ***************************************************
   reg [1:0] div_r;
   reg [1:0] div_nxt;
   reg [8:0] sum;
   reg [7:0] volume_nxt;

   always @*
   begin
      sum = {1'b0, volume_o} + {1'b0, step};
      volume_nxt = volume_o;
      div_nxt = div_r;
      if (!ramping)
      begin
         volume_nxt = volume_i;
         div_nxt = 2'd0;
      end
      else if (speed == `SPEED_INSTANT)
      begin
         volume_nxt = `VOL_MUTE; // [R2]
         div_nxt = 2'd0;
      end
      else if (sample_valid_i)
      begin
         if (div_r >= div_lim)
         begin
            div_nxt = 2'd0;
            if (sum[8])
               volume_nxt = `VOL_MUTE;
            else
               volume_nxt = sum[7:0]; // [R2] [R3]
         end
         else
            div_nxt = div_r + 2'd1;
      end
   end

   always @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         volume_o <= `VOL_MUTE;
         div_r <= 2'd0;
         emergency_o <= 1'b0;
      end
      else
      begin
         volume_o <= volume_nxt;
         div_r <= div_nxt;
         emergency_o <= emg;
      end
   end

endmodule // auto_mute_emergency_ramp

//--- shared/auto_mute_consts.vh
// constants for the auto mute and emergency ramp block
`ifndef AUTO_MUTE_CONSTS_VH
`define AUTO_MUTE_CONSTS_VH

// register offsets
`define ADDR_EMERGENCY_RAMP_SETUP 8'h4f
`define ADDR_SILENCE_MUTE_SETUP 8'h50
`define ADDR_SILENCE_HOLD_TIMES 8'h51
`define ADDR_LOOP_BANDWIDTH_SETUP 8'h53
`define ADDR_MUTE_STATUS 8'h55
`define ADDR_VOLUME_STATUS 8'h56

// reset values
`define RST_EMERGENCY_RAMP_SETUP 8'h30
`define RST_SILENCE_MUTE_SETUP 8'h07
`define RST_SILENCE_HOLD_TIMES 8'h00
`define RST_LOOP_BANDWIDTH_SETUP 8'h00

// field positions
`define EMG_SPEED_HI 7
`define EMG_SPEED_LO 6
`define EMG_STEP_HI 5
`define EMG_STEP_LO 4
`define MUTE_JOINT_BIT 2
`define MUTE_EN_RIGHT_BIT 1
`define MUTE_EN_LEFT_BIT 0
`define THR_LEFT_HI 6
`define THR_LEFT_LO 4
`define THR_RIGHT_HI 2
`define THR_RIGHT_LO 0
`define LOOP_BW_HI 6
`define LOOP_BW_LO 5

// ramp speed codes
`define SPEED_EVERY_1 2'b00
`define SPEED_EVERY_2 2'b01
`define SPEED_EVERY_4 2'b10
`define SPEED_INSTANT 2'b11

// volume codes, 0.5 db per code
`define VOL_MUTE 8'hff
`define VOL_STEP_4DB 8'h08
`define VOL_STEP_2DB 8'h04
`define VOL_STEP_1DB 8'h02
`define VOL_STEP_HALF_DB 8'h01

// silence times in microseconds at the reference rate
`define REF_RATE_HZ 96000
`define SIL_T0_US 11500
`define SIL_T1_US 53000
`define SIL_T2_US 106500
`define SIL_T3_US 266500
`define SIL_T4_US 535000
`define SIL_T5_US 1065000
`define SIL_T6_US 2665000
`define SIL_T7_US 5330000

`endif

//--- rtl/silence_counter.v
// counter of consecutive zero samples on one channel
`timescale 1ns/1ps
module silence_counter #(
   parameter CNT_W = 20
)(
   input wire clk_sys_i,
   input wire rst_n_i,
   input wire sample_valid_i,
   input wire sample_zero_i,
   input wire [2:0] thr_sel_i,
   output reg silent_o
);
`include "auto_mute_consts.vh"

   // ***************************************************
   // threshold in samples, fixed counts so delay scales with fs
   // ***************************************************
   function [CNT_W-1:0] thr_samples;
      input [2:0] sel;
      reg [31:0] us;
      reg [31:0] rate;
      reg [63:0] full;
      begin
         case (sel)
            3'd0: us = `SIL_T0_US;
            3'd1: us = `SIL_T1_US;
            3'd2: us = `SIL_T2_US;
            3'd3: us = `SIL_T3_US;
            3'd4: us = `SIL_T4_US;
            3'd5: us = `SIL_T5_US;
            3'd6: us = `SIL_T6_US;
            default: us = `SIL_T7_US;
         endcase
         rate = `REF_RATE_HZ;
         // microseconds times samples per second, over one million
         full = {32'h0, us} * {32'h0, rate} / 64'hf4240; // [R12]
         thr_samples = full[CNT_W-1:0];
      end
   endfunction

   reg [CNT_W-1:0] cnt_r;
   reg [CNT_W-1:0] cnt_nxt;
   wire [CNT_W-1:0] thr;

   assign thr = thr_samples(thr_sel_i);

   always @*
   begin
      cnt_nxt = cnt_r;
      if (sample_valid_i)
      begin
         if (!sample_zero_i)
            cnt_nxt = {CNT_W{1'b0}}; // [R14]
         else if (cnt_r != {CNT_W{1'b1}})
            cnt_nxt = cnt_r + 1'b1; // [R9] [R11]
      end
   end

   always @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         cnt_r <= {CNT_W{1'b0}};
         silent_o <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         silent_o <= (cnt_nxt >= thr); // [R9] [R11] [R14]
      end
   end

endmodule // silence_counter

//--- verification/amer_props.sv
// assertions for the auto mute and emergency ramp block
`timescale 1ns/1ps
`include "auto_mute_consts.vh"
module amer_props #(
   parameter SAMPLE_W = 24
)(
   input wire clk_sys_i,
   input wire rst_n_i,
   input wire [7:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   input wire [7:0] rdata_o,
   input wire sample_valid_i,
   input wire [SAMPLE_W-1:0] left_sample_i,
   input wire [7:0] volume_i,
   input wire soft_mute_i,
   input wire clock_error_i,
   input wire power_loss_i,
   input wire [7:0] volume_o,
   input wire left_mute_o,
   input wire right_mute_o,
   input wire emergency_o,
   input wire [1:0] loop_bandwidth_select_o
);
   // *****
   // shadow copies of the settings written by software
   // *****
   reg [7:0] emg_r;
   reg [7:0] mute_r;
   reg [7:0] bw_r;
   wire emg_w = clock_error_i | power_loss_i;
   wire [7:0] step_w = 8'h08 >> emg_r[5:4];
   wire [8:0] sum_w = {1'b0, volume_o} + {1'b0, step_w};
   wire [7:0] sat_w = sum_w[8] ? 8'hff : sum_w[7:0];
   always @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         emg_r <= 8'h30;
         mute_r <= 8'h07;
         bw_r <= 8'h00;
      end
      else if (wr_i)
      begin
         if (addr_i == `ADDR_EMERGENCY_RAMP_SETUP) emg_r <= wdata_i;
         if (addr_i == `ADDR_SILENCE_MUTE_SETUP) mute_r <= wdata_i;
         if (addr_i == `ADDR_LOOP_BANDWIDTH_SETUP) bw_r <= wdata_i;
      end
   end
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   sequence bw_write;
      wr_i && addr_i == `ADDR_LOOP_BANDWIDTH_SETUP;
   endsequence
   sequence bw_quiet;
      (!(wr_i && addr_i == `ADDR_LOOP_BANDWIDTH_SETUP))[*2];
   endsequence
   sequence ramp_strobe;
      emg_w && emg_r[7:6] == `SPEED_EVERY_1 && sample_valid_i;
   endsequence
   a_rdata_idle: assert property ($past(rst_n_i) && !$past(rd_i) |-> rdata_o == 8'h00)
      else $error("read data not idle");
   a_emerg_flag: assert property ($past(rst_n_i) |-> emergency_o == $past(emg_w))
      else $error("emergency flag wrong");
   a_instant_mute: assert property (emg_w && emg_r[7:6] == 2'b11 |=> volume_o == 8'hff)
      else $error("instant mute missed");
   a_ramp_step: assert property (ramp_strobe |=> volume_o == $past(sat_w))
      else $error("ramp step wrong");
   a_normal_follow: assert property (!emg_w && !soft_mute_i |=>
      volume_o == $past(volume_i))
      else $error("volume not followed");
   a_left_off: assert property ((!mute_r[0])[*3] |-> !left_mute_o)
      else $error("left muted while disabled");
   a_right_off: assert property ((!mute_r[1])[*3] |-> !right_mute_o)
      else $error("right muted while disabled");
   a_joint_pair: assert property ((mute_r[2:0] == 3'b111)[*3] |->
      left_mute_o == right_mute_o)
      else $error("joint mute split");
   a_left_wake: assert property (sample_valid_i && left_sample_i != {SAMPLE_W{1'b0}} |->
      ##2 !left_mute_o)
      else $error("left not unmuted");
   a_loop_bw: assert property (bw_write ##1 bw_quiet |->
      loop_bandwidth_select_o == bw_r[6:5])
      else $error("bandwidth output wrong");
endmodule // amer_props

bind auto_mute_emergency_ramp amer_props #(.SAMPLE_W(SAMPLE_W)) i_props (
   .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sample_valid_i(sample_valid_i),
   .left_sample_i(left_sample_i), .volume_i(volume_i), .soft_mute_i(soft_mute_i),
   .clock_error_i(clock_error_i), .power_loss_i(power_loss_i), .volume_o(volume_o),
   .left_mute_o(left_mute_o), .right_mute_o(right_mute_o), .emergency_o(emergency_o),
   .loop_bandwidth_select_o(loop_bandwidth_select_o));

//--- verification/auto_mute_emergency_ramp_test.sv
// self-checking bench for the auto mute and emergency ramp block
`timescale 1ns/1ps
module auto_mute_emergency_ramp_test;
   reg clk_sys_i = 1'b0;
   reg rst_n_i = 1'b0;
   reg [7:0] addr_i = 8'h00;
   reg [7:0] wdata_i = 8'h00;
   reg wr_i = 1'b0;
   reg rd_i = 1'b0;
   reg sample_valid_i = 1'b0;
   reg [23:0] left_sample_i = 24'h000001;
   reg [23:0] right_sample_i = 24'h000001;
   reg [7:0] volume_i = 8'h30;
   reg soft_mute_i = 1'b0;
   reg [1:0] normal_speed_i = 2'b11;
   reg [1:0] normal_step_i = 2'b00;
   reg clock_error_i = 1'b0;
   reg power_loss_i = 1'b0;
   wire [7:0] rdata_o;
   wire [7:0] volume_o;
   wire left_mute_o;
   wire right_mute_o;
   wire both_muted_o;
   wire emergency_o;
   wire [1:0] loop_bandwidth_select_o;
   integer fail_count = 0;
   integer samples_checked = 0;
   integer i;
   auto_mute_emergency_ramp i_dut (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sample_valid_i(sample_valid_i),
      .left_sample_i(left_sample_i), .right_sample_i(right_sample_i),
      .volume_i(volume_i), .soft_mute_i(soft_mute_i), .normal_speed_i(normal_speed_i),
      .normal_step_i(normal_step_i), .clock_error_i(clock_error_i), .power_loss_i(power_loss_i),
      .volume_o(volume_o), .left_mute_o(left_mute_o), .right_mute_o(right_mute_o),
      .both_muted_o(both_muted_o), .emergency_o(emergency_o),
      .loop_bandwidth_select_o(loop_bandwidth_select_o));
   // *****
   // access tasks
   // *****
   task check(input [7:0] seen, input [7:0] exp);
   begin
      samples_checked = samples_checked + 1;
      if (seen !== exp)
      begin
         fail_count = fail_count + 1;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   end
   endtask
   task wr(input [7:0] a, input [7:0] d);
   begin
      @(posedge clk_sys_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
   end
   endtask
   task rd(input [7:0] a, input [7:0] exp);
   begin
      @(posedge clk_sys_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
      #1;
      check(rdata_o, exp);
   end
   endtask
   task samp(input [23:0] l, input [23:0] r);
   begin
      @(posedge clk_sys_i);
      sample_valid_i <= 1'b1;
      left_sample_i <= l;
      right_sample_i <= r;
      @(posedge clk_sys_i);
      sample_valid_i <= 1'b0;
   end
   endtask
   task run(input integer n, input [23:0] l, input [23:0] r);
      integer k;
   begin
      for (k = 0; k < n; k = k + 1)
         samp(l, r);
   end
   endtask
   task settle;
   begin
      @(posedge clk_sys_i);
      #1;
   end
   endtask
   task mutes(input [7:0] exp);
   begin
      check({5'h00, both_muted_o, right_mute_o, left_mute_o}, exp);
   end
   endtask
   task final_report;
   begin
      $display("checks %0d failures %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   end
   endtask
   initial
   begin
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end
   initial
   begin
      #300000;
      fail_count = fail_count + 1;
      final_report;
   end
   // *****
   // tests
   // *****
   initial
   begin
      repeat (16) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      rd(8'h4f, 8'h30);
      rd(8'h50, 8'h07);
      rd(8'h51, 8'h00);
      rd(8'h53, 8'h00);
      rd(8'h60, 8'h00);
      wr(8'h4f, 8'h3f);
      rd(8'h4f, 8'h3f);
      wr(8'h51, 8'h88);
      rd(8'h51, 8'h88);
      for (i = 0; i < 4; i = i + 1)
      begin
         wr(8'h53, {1'b1, i[1:0], 5'h1f});
         settle;
         settle;
         check({6'h00, loop_bandwidth_select_o}, i[7:0]);
      end
      // soft mute at instant speed must lose to the emergency settings
      for (i = 0; i < 4; i = i + 1)
      begin
         wr(8'h4f, {2'b00, i[1:0], 4'h0});
         soft_mute_i <= 1'b1;
         clock_error_i <= 1'b1;
         samp(24'h000001, 24'h000001);
         #1;
         check(volume_o, 8'h30 + (8'h08 >> i));
         check({7'h00, emergency_o}, 8'h01);
         @(posedge clk_sys_i);
         clock_error_i <= 1'b0;
         soft_mute_i <= 1'b0;
         settle;
         settle;
      end
      for (i = 0; i < 3; i = i + 1)
      begin
         wr(8'h4f, {i[1:0], 6'h30});
         clock_error_i <= 1'b1;
         run(4, 24'h000001, 24'h000001);
         #1;
         check(volume_o, 8'h30 + (8'h04 >> i));
         @(posedge clk_sys_i);
         clock_error_i <= 1'b0;
         settle;
         settle;
      end
      wr(8'h4f, 8'hc0);
      power_loss_i <= 1'b1;
      settle;
      settle;
      check(volume_o, 8'hff);
      rd(8'h56, 8'hff);
      rd(8'h55, 8'h08);
      @(posedge clk_sys_i);
      power_loss_i <= 1'b0;
      // soft mute alone ramps with the normal settings
      @(posedge clk_sys_i);
      normal_speed_i <= 2'b00;
      normal_step_i <= 2'b01;
      soft_mute_i <= 1'b1;
      samp(24'h000001, 24'h000001);
      #1;
      check(volume_o, 8'h34);
      @(posedge clk_sys_i);
      soft_mute_i <= 1'b0;
      wr(8'h51, 8'h01);
      wr(8'h50, 8'h03);
      samp(24'h000001, 24'h000001);
      run(1103, 24'h000000, 24'h000000);
      settle;
      mutes(8'h00);
      samp(24'h000000, 24'h000000);
      settle;
      mutes(8'h01);
      run(3983, 24'h000000, 24'h000000);
      settle;
      mutes(8'h01);
      samp(24'h000000, 24'h000000);
      settle;
      mutes(8'h07);
      rd(8'h55, 8'h07);
      wr(8'h50, 8'h02);
      settle;
      settle;
      mutes(8'h02);
      wr(8'h50, 8'h01);
      settle;
      settle;
      mutes(8'h01);
      wr(8'h50, 8'h03);
      samp(24'h000001, 24'h000000);
      settle;
      mutes(8'h02);
      wr(8'h50, 8'h07);
      settle;
      settle;
      mutes(8'h00);
      run(1104, 24'h000000, 24'h000000);
      settle;
      mutes(8'h07);
      samp(24'h000000, 24'h800000);
      settle;
      mutes(8'h00);
      final_report;
   end
endmodule // auto_mute_emergency_ramp_test
